// ===== core/mvr_pkg.sv
// Purpose: Shared constants for the monitor housekeeping logic.
// Assumes: 10 MHz core clock; SMBus pins sampled on that clock.
// Notes:   Command codes and register layout live only here.
package mvr_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned CLK_KHZ = 10000;
   localparam int unsigned RST_PULSE_MS = 20;
   // Least time, so exact or rounded up: 20 ms * 10 MHz
   localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * CLK_KHZ;

   // ***************************************************************
   // Bus addresses and command codes
   // ***************************************************************
   localparam logic [6:0] SLV_ADDR_LOW = 7'h2c; // 0101100, strap low
   localparam logic [6:0] SLV_ADDR_HIGH = 7'h2d; // 0101101, strap high
   localparam logic [7:0] CMD_CONFIG = 8'h00;
   localparam logic [7:0] CMD_STATUS1 = 8'h01;
   localparam logic [7:0] CMD_STATUS2 = 8'h02;
   localparam logic [7:0] CMD_VOLT_ID = 8'h03;
   localparam logic [7:0] CMD_VOLT_ID_HI = 8'h04;

   // ***************************************************************
   // Field positions and reset values
   // ***************************************************************
   localparam int unsigned CFG_START_BIT = 0;
   localparam int unsigned CFG_PULSE_BIT = 4;
   localparam int unsigned CFG_SELECT_BIT = 5;
   localparam int unsigned CFG_SWRST_BIT = 7;
   localparam int unsigned VID_RSTEN_BIT = 7;
   localparam int unsigned ST2_DIODE_BIT = 6;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [2:0] MEAS_REMOTE = 3'h0; // First in the sequence
   localparam logic [2:0] MEAS_LOCAL = 3'h1;

   // Serial engine phases
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_ADDR = 3'b001,
      PH_CMD = 3'b010,
      PH_WDAT = 3'b011,
      PH_RDAT = 3'b100
   } mvr_phase_t;

endpackage : mvr_pkg

// ===== core/mvr_pulse_gen.sv
// Purpose: One-shot low-pulse timer for the shared address pin.
// Assumes: start is a one-cycle pulse; reset already synchronised.
// Notes:   A start while busy is ignored, so one pulse per trigger.
`timescale 1ns/1ns
module mvr_pulse_gen
   import mvr_pkg::*;
#(
   parameter int unsigned PULSE_CYC = RST_PULSE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   output logic pulse_busy
);

   localparam int unsigned CW = $clog2(PULSE_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(PULSE_CYC - 1);

   logic [CW-1:0] cnt_ff;
   logic busy_ff;
   wire logic done = busy_ff && (cnt_ff == LAST);

   // ***************************************************************
   // Pulse counter
   // ***************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
      end else if (start && !busy_ff) begin
         busy_ff <= 1'b1; // R8
         cnt_ff <= '0;
      end else if (busy_ff) begin
         busy_ff <= !done;
         cnt_ff <= cnt_ff + CW'(1);
      end
   end

   assign pulse_busy = busy_ff;

   AST_PULSE_LEN: assert property ( // R8
      @(posedge core_clk) disable iff (!rst_n)
      $fell(busy_ff) |-> $past(cnt_ff) == LAST)
      else $error("reset pulse ended early");

endmodule : mvr_pulse_gen

// ===== core/mvr_top.sv
// Purpose: Housekeeping logic: voltage ID, flags, reset pulse, test.
// Assumes: All pins synchronous to core_clk; converter outside.
// Notes:   Summary of operation below.
//
// Summary of operation
// R1: Voltage-ID bits 0..3 show lines 0..3
// R2: Extended register bit 0 shows line hi
// R3: Shared pin analog until config bit 5
// R4: Flag set outside limits, cleared inside
// R5: Flags rewritten every cycle, latest only
// R6: Diode short or open sets status2 bit6
// R7: Diode checked only at remote measurement
// R8: Reset pulse low at least 20 ms
// R9: Reset enable bit 7 gates pin drive
// R10: Config bit 4 rising write starts pulse
// R11: Reset pin drives low, never high
// R12: Host enables reset pulse on one device
// R13: Test mode only if entry pin high
// R14: In test, address pin is chain output
// R15: Tester raises inputs nearest first
// R16: Chain output toggles on each step
// R17: Eight vectors, alternating output levels
// R18: Only write, read, receive byte protocols
// R19: Receive byte returns last selected register
// R20: Nine clocks per byte with acknowledge
// R21: Start, matching address, host stop
// R22: Address latched from strap at power-up
// R23: Config bit 0 runs monitoring loop
// R24: Config bit 7 soft reset, self clearing
// R25: Voltage-ID pins read live
// R26: Read-only writes ignored but acknowledged
`timescale 1ns/1ns
module mvr_top
   import mvr_pkg::*;
#(
   parameter int unsigned PULSE_CYC = RST_PULSE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_strap_pin,
   output logic addr_pin_out,
   output logic addr_pin_oe,
   input wire logic chain_test_entry,
   input wire logic [3:0] volt_id_lines,
   input wire logic volt_id_line_hi,
   output logic shared_pin_id_select,
   output logic monitor_run,
   input wire logic meas_strobe,
   input wire logic [2:0] meas_index,
   input wire logic [7:0] meas_value,
   input wire logic [7:0] meas_lim_hi,
   input wire logic [7:0] meas_lim_lo,
   input wire logic diode_fault
);

   // ***************************************************************
   // Reset release and strap capture
   // ***************************************************************
   logic [1:0] rst_sync_ff;
   wire logic rst_sync_n = rst_sync_ff[1];
   logic boot_done_ff;
   logic addr_hi_ff;
   logic test_mode_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   // Straps caught once after release; later pin use cannot disturb
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         boot_done_ff <= 1'b0;
         addr_hi_ff <= 1'b0;
         test_mode_ff <= 1'b0;
      end else if (!boot_done_ff) begin
         boot_done_ff <= 1'b1;
         addr_hi_ff <= addr_strap_pin; // R22
         test_mode_ff <= chain_test_entry; // R13
      end
   end

   wire logic [6:0] my_addr = addr_hi_ff ? SLV_ADDR_HIGH : SLV_ADDR_LOW;

   // ***************************************************************
   // Serial pin edges
   // ***************************************************************
   logic scl_q_ff;
   logic sda_q_ff;
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= scl_in;
         sda_q_ff <= sda_in;
      end
   end

   // Engine held off until straps are known
   wire logic bus_ok = boot_done_ff && !test_mode_ff;
   wire logic scl_rise = bus_ok && scl_in && !scl_q_ff;
   wire logic scl_fall = bus_ok && !scl_in && scl_q_ff;
   wire logic bus_start = bus_ok && scl_in && scl_q_ff && sda_q_ff
      && !sda_in;
   wire logic bus_stop = bus_ok && scl_in && scl_q_ff && !sda_q_ff
      && sda_in;

   // ***************************************************************
   // Byte engine state
   // ***************************************************************
   mvr_phase_t phase_ff;
   mvr_phase_t nxt_phase;
   logic [3:0] bit_cnt_ff;
   logic in_ack_ff;
   logic ack_drv_ff;
   logic host_ack_ff;
   logic [7:0] rx_ff;
   logic [7:0] tx_ff;
   logic [7:0] ptr_ff;
   logic [7:0] rd_byte;

   wire logic byte_done = scl_fall && !in_ack_ff && (bit_cnt_ff == 4'h8);
   wire logic ack_done = scl_fall && in_ack_ff;
   wire logic addr_hit = (rx_ff[7:1] == my_addr);
   wire logic wr_strobe = byte_done && (phase_ff == PH_WDAT);
   wire logic load_tx = ack_done && (nxt_phase == PH_RDAT);

   // Phase after an acknowledge slot; anything beyond is left alone
   always_comb begin
      nxt_phase = PH_IDLE;
      unique case (phase_ff)
         PH_ADDR: nxt_phase = rx_ff[0] ? PH_RDAT : PH_CMD; // R18
         PH_CMD: nxt_phase = PH_WDAT;
         PH_RDAT: nxt_phase = host_ack_ff ? PH_RDAT : PH_IDLE;
         PH_WDAT: nxt_phase = PH_IDLE;
         PH_IDLE: nxt_phase = PH_IDLE;
      endcase
   end

   // Phase sequencing around start, stop and acknowledge
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase_ff <= PH_IDLE;
      end else if (bus_start) begin
         phase_ff <= PH_ADDR; // R21
      end else if (bus_stop) begin
         phase_ff <= PH_IDLE; // R21
      end else if (byte_done && phase_ff == PH_ADDR && !addr_hit) begin
         phase_ff <= PH_IDLE;
      end else if (ack_done) begin
         phase_ff <= nxt_phase;
      end
   end

   // Bit counting: eight data clocks then one acknowledge clock
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bit_cnt_ff <= 4'h0;
         in_ack_ff <= 1'b0;
      end else if (bus_start || bus_stop || ack_done) begin
         bit_cnt_ff <= 4'h0; // R20
         in_ack_ff <= 1'b0;
      end else if (byte_done && phase_ff != PH_IDLE) begin
         in_ack_ff <= 1'b1; // R20
      end else if (scl_rise && !in_ack_ff && bit_cnt_ff != 4'h8) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   // Receive shift and acknowledge decisions
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_ff <= 8'h00;
         ack_drv_ff <= 1'b0;
         host_ack_ff <= 1'b0;
      end else begin
         if (scl_rise && !in_ack_ff) begin
            rx_ff <= {rx_ff[6:0], sda_in};
         end
         if (scl_rise && in_ack_ff) begin
            host_ack_ff <= !sda_in;
         end
         if (byte_done) begin
            // Writes to read-only fields are still acknowledged
            ack_drv_ff <= (phase_ff == PH_ADDR) ? addr_hit
               : (phase_ff == PH_CMD || phase_ff == PH_WDAT); // R26
         end else if (ack_done || bus_stop) begin
            ack_drv_ff <= 1'b0;
         end
      end
   end

   // Command byte selects the register; no new command on receive
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ptr_ff <= CMD_CONFIG;
      end else if (byte_done && phase_ff == PH_CMD) begin
         ptr_ff <= rx_ff; // R19
      end
   end

   // Transmit shift: MSB first, changed only while SCL is low
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_ff <= 8'hff;
      end else if (load_tx) begin
         tx_ff <= rd_byte; // R19
      end else if (scl_fall && phase_ff == PH_RDAT && !in_ack_ff
                   && bit_cnt_ff != 4'h8) begin
         tx_ff <= {tx_ff[6:0], 1'b1};
      end
   end

   // Open-drain data line: only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe = (in_ack_ff && ack_drv_ff)
      || (phase_ff == PH_RDAT && !in_ack_ff
          && !tx_ff[7]); // LSB held past SCL high: no false stop

   // ***************************************************************
   // Configuration and voltage-ID registers
   // ***************************************************************
   logic [7:0] cfg_ff;
   logic rst_en_ff;
   logic sw_rst_ff;
   wire logic wr_cfg = wr_strobe && (ptr_ff == CMD_CONFIG);
   wire logic wr_vid = wr_strobe && (ptr_ff == CMD_VOLT_ID);
   // Only a 0 to 1 change of the trigger bit counts
   wire logic pulse_edge = wr_cfg && rx_ff[CFG_PULSE_BIT]
      && !cfg_ff[CFG_PULSE_BIT];
   wire logic pulse_start = pulse_edge && rst_en_ff; // R10
   wire logic sel_hi = cfg_ff[CFG_SELECT_BIT];

   // Soft reset bit is never stored, so it reads back as zero
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cfg_ff <= CFG_RESET;
         rst_en_ff <= 1'b0;
         sw_rst_ff <= 1'b0;
      end else if (sw_rst_ff) begin
         cfg_ff <= CFG_RESET; // R24
         rst_en_ff <= 1'b0;
         sw_rst_ff <= 1'b0;
      end else begin
         sw_rst_ff <= wr_cfg && rx_ff[CFG_SWRST_BIT]; // R24
         if (wr_cfg) begin
            cfg_ff <= {1'b0, rx_ff[6:0]}; // R23 R3
         end
         if (wr_vid) begin
            rst_en_ff <= rx_ff[VID_RSTEN_BIT]; // R9 R26
         end
      end
   end

   assign monitor_run = cfg_ff[CFG_START_BIT]; // R23
   assign shared_pin_id_select = sel_hi; // R3

   // ***************************************************************
   // Limit flags
   // ***************************************************************
   logic [7:0] status1_ff;
   logic diode_ff;

   // Temperature channels compare as two's complement, volts unsigned
   function automatic logic out_of_lim(input logic [2:0] idx,
                                       input logic [7:0] v,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
      logic tmp;
      tmp = (idx == MEAS_REMOTE) || (idx == MEAS_LOCAL);
      if (tmp) begin
         out_of_lim = ($signed(v) > $signed(hi))
            || ($signed(v) < $signed(lo));
      end else begin
         out_of_lim = (v > hi) || (v < lo);
      end
   endfunction : out_of_lim

   wire logic meas_ok = meas_strobe && monitor_run && !sw_rst_ff;
   wire logic meas_bad = out_of_lim(meas_index, meas_value, meas_lim_hi,
                                    meas_lim_lo);

   // Each result overwrites its flag: no stale violation survives
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         status1_ff <= STATUS_RESET;
         diode_ff <= 1'b0;
      end else if (sw_rst_ff) begin
         status1_ff <= STATUS_RESET;
         diode_ff <= 1'b0;
      end else if (meas_ok) begin
         status1_ff[meas_index] <= meas_bad; // R4 R5
         if (meas_index == MEAS_REMOTE) begin
            diode_ff <= diode_fault; // R6 R7
         end
      end
   end

   // ***************************************************************
   // Read multiplexer
   // ***************************************************************
   wire logic [7:0] vid_rd = {rst_en_ff, 3'h0, volt_id_lines}; // R1 R25
   wire logic [7:0] vid_hi_rd = {7'h00, sel_hi && volt_id_line_hi}; // R2
   wire logic [7:0] st2_rd = 8'(diode_ff) << ST2_DIODE_BIT;

   always_comb begin
      unique case (ptr_ff)
         CMD_CONFIG: rd_byte = cfg_ff;
         CMD_STATUS1: rd_byte = status1_ff;
         CMD_STATUS2: rd_byte = st2_rd;
         CMD_VOLT_ID: rd_byte = vid_rd;
         CMD_VOLT_ID_HI: rd_byte = vid_hi_rd;
         default: rd_byte = 8'h00;
      endcase
   end

   // ***************************************************************
   // Reset pulse and test chain on the shared address pin
   // ***************************************************************
   logic pulse_busy;
   logic chain_ff;
   wire logic [6:0] chain_vec = {sda_in, scl_in, volt_id_lines[0],
      volt_id_lines[1], volt_id_lines[2], volt_id_lines[3],
      volt_id_line_hi};
   logic [6:0] chain_prev_ff;

   mvr_pulse_gen #(
      .PULSE_CYC(PULSE_CYC)
   ) u_pulse (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .start(pulse_start),
      .pulse_busy(pulse_busy)
   );

   // NAND chain, farthest input first; all-low input gives high
   function automatic logic nand_chain(input logic [6:0] v);
      logic acc;
      acc = 1'b1;
      for (int i = 6; i >= 0; i--) begin
         acc = !(v[i] && acc);
      end
      nand_chain = acc;
   endfunction : nand_chain

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         chain_ff <= 1'b1;
         chain_prev_ff <= 7'h00;
      end else begin
         chain_ff <= nand_chain(chain_vec); // R16 R17
         chain_prev_ff <= chain_vec;
      end
   end

   // Reset use is open drain; test use drives both levels
   assign addr_pin_out = test_mode_ff ? chain_ff : 1'b0; // R11 R14
   assign addr_pin_oe = test_mode_ff
      || (pulse_busy && rst_en_ff); // R9 R8

   // ***************************************************************
   // Checks
   // ***************************************************************
   sequence s_addr_byte;
      byte_done && phase_ff == PH_ADDR && addr_hit;
   endsequence

   sequence s_ack_slot;
      sda_oe [*1] ##0 in_ack_ff;
   endsequence

   AST_ADDR_ACK: assert property ( // R21
      @(posedge core_clk) disable iff (!rst_sync_n)
      s_addr_byte |=> s_ack_slot)
      else $error("matching address not acknowledged");

   AST_NINE_CLK: assert property ( // R20
      @(posedge core_clk) disable iff (!rst_sync_n)
      ack_done |-> $past(bit_cnt_ff) == 4'h8)
      else $error("acknowledge not on ninth clock");

   AST_VID_HI_ZERO: assert property ( // R2
      @(posedge core_clk) disable iff (!rst_sync_n)
      !sel_hi |-> vid_hi_rd == 8'h00)
      else $error("extended id bit set while unselected");

   AST_FLAG: assert property ( // R4
      @(posedge core_clk) disable iff (!rst_sync_n)
      meas_ok |=> status1_ff[$past(meas_index)] == $past(meas_bad))
      else $error("status flag not rewritten");

   AST_DIODE_HOLD: assert property ( // R7
      @(posedge core_clk) disable iff (!rst_sync_n)
      !(meas_ok && meas_index == MEAS_REMOTE) && !sw_rst_ff
      |=> $stable(diode_ff))
      else $error("diode flag moved outside remote step");

   AST_NO_DRIVE: assert property ( // R9
      @(posedge core_clk) disable iff (!rst_sync_n)
      !test_mode_ff && !rst_en_ff |-> !addr_pin_oe)
      else $error("address pin driven without enable");

   AST_TRIGGER: assert property ( // R10
      @(posedge core_clk) disable iff (!rst_sync_n)
      pulse_start && !pulse_busy |=> addr_pin_oe [*2])
      else $error("pulse not started on trigger edge");

   AST_OPEN_DRAIN: assert property ( // R11
      @(posedge core_clk) disable iff (!rst_sync_n)
      !test_mode_ff |-> addr_pin_out == 1'b0)
      else $error("address pin driven high");

   AST_CHAIN_STEP: assert property ( // R16
      @(posedge core_clk) disable iff (!rst_sync_n)
      test_mode_ff && chain_vec != chain_prev_ff
      && chain_vec == {chain_prev_ff[5:0], 1'b1}
      |=> chain_ff != $past(chain_ff))
      else $error("chain output did not toggle");

   AST_SWRST: assert property ( // R24
      @(posedge core_clk) disable iff (!rst_sync_n)
      sw_rst_ff |=> cfg_ff == CFG_RESET && !rst_en_ff)
      else $error("soft reset did not clear control");

endmodule : mvr_top

// ===== sim/mvr_smb_host.sv
// Purpose: SMBus host model for the monitor serial port.
// Assumes: Pull-up on SDA; 3 core cycles per bus phase.
// Notes:   Bus rests high between frames; no clock outside frames.
`timescale 1ns/1ns
module mvr_smb_host (
   input wire logic core_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv
);
   logic [6:0] dev_addr = 7'h2c;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // *****
   // Bus phases
   // *****
   // Three cycles a phase, above the two the slave needs
   task automatic hp;
      repeat (3) @(posedge core_clk);
      #1;
   endtask : hp
   // Also serves as repeated start
   task automatic sta;
      sda_drv = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_drv = 1'b0;
      hp();
      scl = 1'b0;
      hp();
   endtask : sta
   task automatic sto;
      sda_drv = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_drv = 1'b1;
      hp();
   endtask : sto
   // Data held through the whole high phase
   task automatic bx(input logic b, output logic r);
      sda_drv = b;
      hp();
      scl = 1'b1;
      hp();
      r = sda_line;
      scl = 1'b0;
      hp();
   endtask : bx
   // Eight bits MSB first, then the slave's acknowledge
   task automatic bw(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bx(d[i], r);
      bx(1'b1, r);
      ack = ~r;
   endtask : bw
   task automatic br(output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bx(1'b1, r);
         d = {d[6:0], r};
      end
      bx(1'b1, r);
   endtask : br
   // *****
   // Protocols
   // *****
   task automatic wr(input logic [7:0] c, d, output logic ok);
      logic a0, a1, a2;
      sta();
      bw({dev_addr, 1'b0}, a0);
      bw(c, a1);
      bw(d, a2);
      sto();
      ok = a0 & a1 & a2;
   endtask : wr
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      logic a;
      sta();
      bw({dev_addr, 1'b0}, a);
      bw(c, a);
      sta();
      bw({dev_addr, 1'b1}, a);
      br(d);
      sto();
   endtask : rd
   task automatic rcv(output logic [7:0] d);
      logic a;
      sta();
      bw({dev_addr, 1'b1}, a);
      br(d);
      sto();
   endtask : rcv
   // Tester use of the bus pins as chain inputs
   task automatic set_lines(input logic c, d);
      scl = c;
      sda_drv = d;
   endtask : set_lines
endmodule : mvr_smb_host

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the monitor housekeeping logic.
// Assumes: Pulse length shortened to 50 cycles.
// Notes:   Expectations come from bench functions, not the design.
`timescale 1ns/1ns
module tb_top;
   import mvr_pkg::*;
   localparam int unsigned PCYC = 50;
   logic core_clk, rst_n, strap_lvl, chain_test_entry, volt_id_line_hi;
   logic [3:0] volt_id_lines;
   logic meas_strobe, diode_fault, in_test, prev_oe, ok;
   logic [2:0] meas_index;
   logic [7:0] meas_value, meas_lim_hi, meas_lim_lo, st1, rdv, v;
   logic sda_out, sda_oe, addr_pin_out, addr_pin_oe, scl, sda_drv;
   logic shared_pin_id_select, monitor_run;
   wire sda_line, addr_level;
   int n_errors, num_checks, cyc, seed, oe_cyc, n_pulse;
   // Open-drain wires with pull-up or strap level
   assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
   assign addr_level = addr_pin_oe ? addr_pin_out : strap_lvl;
   mvr_top #(.PULSE_CYC(PCYC)) u_mvr_top (.core_clk(core_clk),
      .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pin(addr_level),
      .addr_pin_out(addr_pin_out), .addr_pin_oe(addr_pin_oe),
      .chain_test_entry(chain_test_entry), .volt_id_lines(volt_id_lines),
      .volt_id_line_hi(volt_id_line_hi),
      .shared_pin_id_select(shared_pin_id_select),
      .monitor_run(monitor_run), .meas_strobe(meas_strobe),
      .meas_index(meas_index), .meas_value(meas_value),
      .meas_lim_hi(meas_lim_hi), .meas_lim_lo(meas_lim_lo),
      .diode_fault(diode_fault));
   mvr_smb_host u_mvr_smb_host (.core_clk(core_clk),
      .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // *****
   // Checking and closing
   // *****
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   function automatic logic flag_exp(input logic [7:0] x, hi, lo);
      return (x > hi) || (x < lo);
   endfunction : flag_exp
   function automatic logic chain_exp(input int k);
      return (k % 2) == 0;
   endfunction : chain_exp
   // Pulse watcher; the cycle ceiling cuts a hang short
   always @(posedge core_clk) begin
      cyc++;
      if (addr_pin_oe === 1'b1 && !in_test) begin
         oe_cyc++;
         if (!prev_oe) n_pulse++;
         chk("pin low", addr_pin_out, 16'h0);
      end
      prev_oe = (addr_pin_oe === 1'b1);
      if (cyc >= 40000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic power_up(input logic s, t);
      rst_n = 1'b0;
      strap_lvl = s;
      chain_test_entry = t;
      in_test = t;
      repeat (20) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      repeat (6) @(posedge core_clk);
      #1;
   endtask : power_up
   task automatic meas(input logic [2:0] i, input logic [7:0] x, hi, lo,
                       input logic f);
      meas_index = i;
      meas_value = x;
      meas_lim_hi = hi;
      meas_lim_lo = lo;
      diode_fault = f;
      meas_strobe = 1'b1;
      @(posedge core_clk);
      #1;
      meas_strobe = 1'b0;
      st1[i] = flag_exp(x, hi, lo);
      @(posedge core_clk);
      #1;
   endtask : meas
   // *****
   // Main sequence
   // *****
   initial begin
      seed = 32'h687b;
      {n_errors, num_checks, cyc, oe_cyc, n_pulse} = '0;
      {prev_oe, volt_id_lines, volt_id_line_hi, meas_strobe} = '0;
      {meas_index, meas_value, meas_lim_hi, meas_lim_lo, diode_fault} = '0;
      st1 = 8'h00;
      power_up(1'b0, 1'b0);
      chk("run idle", monitor_run, 16'h0);
      chk("pin idle", addr_pin_oe, 16'h0);
      u_mvr_smb_host.rd(CMD_VOLT_ID_HI, rdv);
      chk("hi default", rdv, 16'h0);
      repeat (4) begin
         volt_id_lines = 4'($random(seed));
         u_mvr_smb_host.rd(CMD_VOLT_ID, rdv);
         chk("id lines", rdv[3:0], volt_id_lines);
      end
      volt_id_lines = 4'h0;
      // Trigger with enable clear must not drive the pin
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h10, ok);
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h00, ok);
      chk("no enable", oe_cyc[15:0], 16'h0);
      // Only this one device enables the pulse on its bus
      u_mvr_smb_host.wr(CMD_VOLT_ID, 8'h8f, ok);
      chk("ro ack", ok, 16'h1);
      u_mvr_smb_host.rd(CMD_VOLT_ID, rdv);
      chk("ro kept", rdv, 16'h80);
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h10, ok);
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h10, ok);
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h00, ok);
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h10, ok);
      repeat (PCYC + 5) @(posedge core_clk);
      #1;
      chk("pulses", n_pulse[15:0], 16'h2);
      chk("pulse len", oe_cyc[15:0], 16'(2 * PCYC));
      u_mvr_smb_host.wr(CMD_VOLT_ID, 8'h00, ok);
      volt_id_line_hi = 1'b1;
      u_mvr_smb_host.rd(CMD_VOLT_ID_HI, rdv);
      chk("hi unsel", rdv, 16'h0);
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h21, ok);
      chk("select", shared_pin_id_select, 16'h1);
      chk("run", monitor_run, 16'h1);
      u_mvr_smb_host.rd(CMD_VOLT_ID_HI, rdv);
      chk("hi sel", rdv, 16'h1);
      // Values kept below 128 so signed and plain compares agree
      repeat (10) begin
         v = 8'($random(seed)) & 8'h7f;
         meas(3'($random(seed)), v, v ^ 8'h08, v ^ 8'h04, 1'b0);
      end
      meas(3'h5, 8'h41, 8'h40, 8'h10, 1'b0);
      u_mvr_smb_host.rd(CMD_STATUS1, rdv);
      chk("flags", rdv, st1);
      meas(3'h5, 8'h40, 8'h40, 8'h40, 1'b0);
      u_mvr_smb_host.rd(CMD_STATUS1, rdv);
      chk("flags new", rdv, st1);
      meas(MEAS_REMOTE, 8'h20, 8'h7f, 8'h00, 1'b1);
      meas(3'h4, 8'h20, 8'h7f, 8'h00, 1'b0);
      u_mvr_smb_host.rd(CMD_STATUS2, rdv);
      chk("diode set", rdv[6], 16'h1);
      meas(MEAS_REMOTE, 8'h20, 8'h7f, 8'h00, 1'b0);
      meas(3'h4, 8'h20, 8'h7f, 8'h00, 1'b1);
      u_mvr_smb_host.rd(CMD_STATUS2, rdv);
      chk("diode clr", rdv[6], 16'h0);
      u_mvr_smb_host.rd(CMD_CONFIG, rdv);
      u_mvr_smb_host.rcv(rdv);
      chk("receive", rdv, 16'h21);
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h80, ok);
      u_mvr_smb_host.rd(CMD_CONFIG, rdv);
      chk("soft rst", rdv, 16'h0);
      chk("soft run", monitor_run, 16'h0);
      u_mvr_smb_host.dev_addr = SLV_ADDR_HIGH;
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h01, ok);
      chk("bad addr", {ok, monitor_run}, 16'h0);
      power_up(1'b1, 1'b0);
      u_mvr_smb_host.wr(CMD_CONFIG, 8'h01, ok);
      chk("strap hi", {ok, monitor_run}, 16'h3);
      // All chain inputs low, then raised nearest first
      u_mvr_smb_host.set_lines(1'b0, 1'b0);
      volt_id_line_hi = 1'b0;
      power_up(1'b0, 1'b1);
      for (int k = 0; k < 8; k++) begin
         v = 8'((16'h1 << k) - 16'h1);
         volt_id_line_hi = v[0];
         volt_id_lines = {v[1], v[2], v[3], v[4]};
         u_mvr_smb_host.set_lines(v[5], v[6]);
         repeat (3) @(posedge core_clk);
         #1;
         chk("chain oe", addr_pin_oe, 16'h1);
         chk("chain out", addr_pin_out, 16'(chain_exp(k)));
      end
      test_done();
   end
endmodule : tb_top
